/* File: rbst_pkg.sv */
// Constants and register map for the remote binary signal transfer block
package rbst_pkg;
    // Item counts
    localparam int NUM_FAST      = 4;
    localparam int NUM_GEN       = 24;
    localparam int NUM_PEERS_DEF = 2;
    localparam int GRP_BITS      = 4;
    localparam int NUM_GRP       = NUM_GEN / GRP_BITS;
    localparam int GRP_IDX_W     = 3;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

    // Clear delay in milliseconds, 0.00 to 300.00 s, default 0.00 s
    localparam int DELAY_W = 19;
    localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 19'd300000;
    localparam logic [DELAY_W-1:0] DELAY_DEF_MS = 19'd0;
    localparam int DELAY_INF_BIT = 31;

    // Framing and stability defaults
    localparam int FRAME_CYCLES_DEF  = 16;
    localparam int STABLE_CYCLES_DEF = 1024;

    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_DELAY    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_TX_IMAGE = 8'h10;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: bit_sync.sv */
// Two-flop synchroniser for a bundle of independent pin levels
`timescale 1ns/100ps
`default_nettype none
module bit_sync
#(
    parameter int W = 1
)
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } state_s;

    state_s s;
    state_s next_s;

    // First stage feeds only the second
    always_comb
    begin
        next_s      = s;
        next_s.meta = d;
        next_s.q    = s.meta;
    end

    // State register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign q = s.q;
endmodule // bit_sync
`default_nettype wire

/* File: clear_timer.sv */
// Delay timer that expires a set time after a link fault begins
`timescale 1ns/100ps
`default_nettype none
module clear_timer
    import rbst_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               fault,
    input  wire logic [DELAY_W-1:0] delay_ms,
    input  wire logic               delay_inf,
    output logic                    expire
);
    localparam int MW = $clog2(MS_CYCLES + 1);
    localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);

    typedef struct packed {
        logic               fault_q;
        logic               running;
        logic [DELAY_W-1:0] ms_left;
        logic [MW-1:0]      sub;
        logic               expire;
    } state_s;

    state_s s;
    state_s next_s;

    // Start on fault onset, count whole ms, stop if link recovers
    always_comb
    begin
        next_s         = s;
        next_s.expire  = 1'b0;
        next_s.fault_q = fault;
        if (!fault)
            next_s.running = 1'b0;
        else if (!s.fault_q)
        begin
            next_s.sub = '0;
            if (delay_inf)
                next_s.running = 1'b0;
            else if (delay_ms == '0)
                next_s.expire = 1'b1;
            else
            begin
                next_s.running = 1'b1;
                next_s.ms_left = delay_ms;
            end
        end
        else if (s.running)
        begin
            if (s.sub == MS_LAST)
            begin
                next_s.sub     = '0;
                next_s.ms_left = s.ms_left - 1'b1;
                if (s.ms_left == DELAY_W'(1))
                begin
                    next_s.running = 1'b0;
                    next_s.expire  = 1'b1;
                end
            end
            else
                next_s.sub = s.sub + 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign expire = s.expire;
endmodule // clear_timer
`default_nettype wire

/* File: remote_binary_signal_transfer.sv */
// Remote binary signal transfer: send, receive, peer status, registers
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Up to 28 extra items go to peers only over the data link.
// - Four items go out at once with protection priority.
// - The other 24 items go out in the background.
// - Fast inputs 1 to 4 drive fast outputs 1 to 4 at peers.
// - General inputs 1 to 24 drive matching general outputs at peers.
// - Without setup every item is broadcast to all peers.
// - Logout does not stop sending or receiving.
// - Peer-available is set only while that peer is active and stable.
// - A link fault starts the delay after which received items clear.
// - The clear delay is 0.00 to 300.00 s or infinite, default 0.00 s.
module remote_binary_signal_transfer
    import rbst_pkg::*;
#(
    parameter int NUM_PEERS     = NUM_PEERS_DEF,
    parameter int FRAME_CYCLES  = FRAME_CYCLES_DEF,
    parameter int STABLE_CYCLES = STABLE_CYCLES_DEF,
    parameter int MS_CYCLES     = MS_CYCLES_DEF
)
(
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]                     awaddr,
    input  wire logic                                  awvalid,
    output logic                                       awready,
    input  wire logic [31:0]                           wdata,
    input  wire logic [3:0]                            wstrb,
    input  wire logic                                  wvalid,
    output logic                                       wready,
    output logic [1:0]                                 bresp,
    output logic                                       bvalid,
    input  wire logic                                  bready,
    input  wire logic [ADDR_W-1:0]                     araddr,
    input  wire logic                                  arvalid,
    output logic                                       arready,
    output logic [31:0]                                rdata,
    output logic [1:0]                                 rresp,
    output logic                                       rvalid,
    input  wire logic                                  rready,
    output logic                                       irq,
    // Local binary inputs (pins)
    input  wire logic [NUM_FAST-1:0]                   fast_trip_in,
    input  wire logic [NUM_GEN-1:0]                    gen_in,
    // Local status from topology logic
    input  wire logic                                  functional_logout,
    input  wire logic [NUM_PEERS-1:0]                  peer_active,
    // Outgoing link frame, one broadcast to all peers
    output logic                                       link_tx_valid,
    output logic [NUM_FAST-1:0]                        link_tx_fast,
    output logic [GRP_IDX_W-1:0]                       link_tx_grp,
    output logic [GRP_BITS-1:0]                        link_tx_bg,
    // Incoming link frames, one lane per peer
    input  wire logic [NUM_PEERS-1:0]                  link_rx_valid,
    input  wire logic [NUM_PEERS-1:0][NUM_FAST-1:0]    link_rx_fast,
    input  wire logic [NUM_PEERS-1:0][GRP_IDX_W-1:0]   link_rx_grp,
    input  wire logic [NUM_PEERS-1:0][GRP_BITS-1:0]    link_rx_bg,
    input  wire logic [NUM_PEERS-1:0]                  link_fault,
    // Received items and peer status
    output logic [NUM_PEERS-1:0][NUM_FAST-1:0]         fast_trip_rx,
    output logic [NUM_PEERS-1:0][NUM_GEN-1:0]          gen_rx,
    output logic [NUM_PEERS-1:0]                       peer_avail
);
    localparam int FW    = $clog2(FRAME_CYCLES + 1);
    localparam int SW    = $clog2(STABLE_CYCLES + 1);
    localparam int IRQ_W = 3 * NUM_PEERS;
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);
    localparam logic [SW-1:0] STABLE_N   = SW'(STABLE_CYCLES);
    localparam logic [GRP_IDX_W-1:0] GRP_LAST = GRP_IDX_W'(NUM_GRP - 1);
    localparam logic [GRP_IDX_W-1:0] GRP_CNT  = GRP_IDX_W'(NUM_GRP);

    typedef struct packed {
        logic                                awready;
        logic                                wready;
        logic                                arready;
        logic                                aw_held;
        logic [ADDR_W-1:0]                   aw_addr;
        logic                                w_held;
        logic [31:0]                         w_data;
        logic [3:0]                          w_strb;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [31:0]                         rdata;
        logic [1:0]                          rresp;
        logic [DELAY_W-1:0]                  delay_ms;
        logic                                delay_inf;
        logic [IRQ_W-1:0]                    irq_stat;
        logic [IRQ_W-1:0]                    irq_mask;
        logic                                irq;
        logic [FW-1:0]                       frame_cnt;
        logic [GRP_IDX_W-1:0]                grp;
        logic                                tx_valid;
        logic [NUM_FAST-1:0]                 tx_fast;
        logic [GRP_IDX_W-1:0]                tx_grp;
        logic [GRP_BITS-1:0]                 tx_bg;
        logic [NUM_PEERS-1:0]                fault_q;
        logic [NUM_PEERS-1:0][NUM_FAST-1:0]  rx_fast;
        logic [NUM_PEERS-1:0][NUM_GEN-1:0]   rx_gen;
        logic [NUM_PEERS-1:0][SW-1:0]        stab_cnt;
        logic [NUM_PEERS-1:0]                avail;
    } state_s;

    state_s                s;
    state_s                next_s;
    logic [NUM_FAST-1:0]   fast_now;
    logic [NUM_GEN-1:0]    gen_now;
    logic [NUM_PEERS-1:0]  expire;
    logic                  wr_go;
    logic                  rd_clr;
    logic [31:0]           wr_val;
    logic [31:0]           rd_val;
    logic [IRQ_W-1:0]      events;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        return r;
    endfunction

    // Binary inputs arrive from pins
    bit_sync #(
        .W (NUM_FAST + NUM_GEN)
    ) u_in_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({gen_in, fast_trip_in}),
        .q        ({gen_now, fast_now})
    );

    // One clear-delay timer per peer
    for (genvar p = 0; p < NUM_PEERS; p++)
    begin : g_peer
        clear_timer #(
            .MS_CYCLES (MS_CYCLES)
        ) u_timer (
            .core_clk  (core_clk),
            .rst       (rst),
            .fault     (link_fault[p]),
            .delay_ms  (s.delay_ms),
            .delay_inf (s.delay_inf),
            .expire    (expire[p])
        );
    end

    // Read data mux
    always_comb
    begin
        rd_val = '0;
        case (araddr)
            REG_DELAY:
                rd_val = {s.delay_inf, 12'h000, s.delay_ms};
            REG_STATUS:
                rd_val = 32'({functional_logout, s.fault_q, s.avail});
            REG_IRQ_STAT:
                rd_val = 32'(s.irq_stat);
            REG_IRQ_MASK:
                rd_val = 32'(s.irq_mask);
            REG_TX_IMAGE:
                rd_val = {4'h0, gen_now, fast_now};
            default:
                rd_val = '0;
        endcase
    end

    // Next state
    always_comb
    begin
        next_s   = s;
        wr_go    = 1'b0;
        rd_clr   = 1'b0;
        wr_val   = '0;
        events   = '0;

        // Write: address and data in either order
        if (bready && s.bvalid)
            next_s.bvalid = 1'b0;
        if (awvalid && s.awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && s.wready)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (next_s.aw_held && next_s.w_held && !next_s.bvalid)
        begin
            wr_go          = 1'b1;
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
        end
        if (wr_go)
        begin
            case (next_s.aw_addr)
                REG_DELAY:
                begin
                    wr_val = merge({s.delay_inf, 12'h000, s.delay_ms},
                                   next_s.w_data, next_s.w_strb);
                    next_s.delay_inf = wr_val[DELAY_INF_BIT];
                    if (wr_val[DELAY_W-1:0] > DELAY_MAX_MS)
                        next_s.delay_ms = DELAY_MAX_MS;
                    else
                        next_s.delay_ms = wr_val[DELAY_W-1:0];
                end
                REG_IRQ_MASK:
                begin
                    wr_val = merge(32'(s.irq_mask), next_s.w_data,
                                   next_s.w_strb);
                    next_s.irq_mask = wr_val[IRQ_W-1:0];
                end
                REG_STATUS, REG_IRQ_STAT, REG_TX_IMAGE:
                    next_s.bresp = RESP_OKAY;
                default:
                    next_s.bresp = RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;

        // Read; interrupt status read clears sticky bits
        if (rready && s.rvalid)
            next_s.rvalid = 1'b0;
        if (arvalid && s.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_val;
            rd_clr        = (araddr == REG_IRQ_STAT);
            case (araddr)
                REG_DELAY, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
                REG_TX_IMAGE:
                    next_s.rresp = RESP_OKAY;
                default:
                    next_s.rresp = RESP_SLVERR;
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // Transmit on fast change or frame tick
        next_s.tx_valid = 1'b0;
        if (s.frame_cnt == FRAME_LAST || fast_now != s.tx_fast)
        begin
            next_s.tx_valid  = 1'b1;
            next_s.tx_fast   = fast_now;
            next_s.tx_grp    = s.grp;
            next_s.tx_bg     = gen_now[s.grp * GRP_BITS +: GRP_BITS];
            next_s.grp       = (s.grp == GRP_LAST) ? '0 : s.grp + 1'b1;
            next_s.frame_cnt = '0;
        end
        else
            next_s.frame_cnt = s.frame_cnt + 1'b1;

        // Receive per peer; logout gates nothing
        for (int p = 0; p < NUM_PEERS; p++)
        begin
            next_s.fault_q[p] = link_fault[p];
            if (link_fault[p] && !s.fault_q[p])
                events[p] = 1'b1;
            if (expire[p])
            begin
                next_s.rx_fast[p]      = '0;
                next_s.rx_gen[p]       = '0;
                events[NUM_PEERS + p]  = 1'b1;
            end
            else if (link_rx_valid[p] && !link_fault[p])
            begin
                next_s.rx_fast[p] = link_rx_fast[p];
                if (|(link_rx_fast[p] & ~s.rx_fast[p]))
                    events[2 * NUM_PEERS + p] = 1'b1;
                if (link_rx_grp[p] < GRP_CNT)
                    next_s.rx_gen[p][link_rx_grp[p] * GRP_BITS +: GRP_BITS]
                        = link_rx_bg[p];
            end

            // Available after a steady fault-free active run
            if (peer_active[p] && !link_fault[p])
            begin
                if (s.stab_cnt[p] != STABLE_N)
                    next_s.stab_cnt[p] = s.stab_cnt[p] + 1'b1;
            end
            else
                next_s.stab_cnt[p] = '0;
            next_s.avail[p] = (next_s.stab_cnt[p] == STABLE_N);
        end

        // Sticky status: a new event wins over the read clear
        next_s.irq_stat = (rd_clr ? '0 : s.irq_stat) | events;
        next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
    end

    // State register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s          <= '0;
            s.delay_ms <= DELAY_DEF_MS;
        end
        else
            s <= next_s;
    end

    // Outputs straight from flops
    assign awready       = s.awready;
    assign wready        = s.wready;
    assign bvalid        = s.bvalid;
    assign bresp         = s.bresp;
    assign arready       = s.arready;
    assign rvalid        = s.rvalid;
    assign rdata         = s.rdata;
    assign rresp         = s.rresp;
    assign irq           = s.irq;
    assign link_tx_valid = s.tx_valid;
    assign link_tx_fast  = s.tx_fast;
    assign link_tx_grp   = s.tx_grp;
    assign link_tx_bg    = s.tx_bg;
    assign fast_trip_rx  = s.rx_fast;
    assign gen_rx        = s.rx_gen;
    assign peer_avail    = s.avail;
endmodule // remote_binary_signal_transfer
`default_nettype wire

/* File: rbst_asserts.sv */
// Port checks for the remote binary signal transfer block
`timescale 1ns/100ps
`default_nettype none
module rbst_asserts
    import rbst_pkg::*;
#(
    parameter int NUM_PEERS    = NUM_PEERS_DEF,
    parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
)
(
    input wire logic                                core_clk,
    input wire logic                                rst,
    input wire logic                                bvalid,
    input wire logic                                bready,
    input wire logic [NUM_FAST-1:0]                 fast_trip_in,
    input wire logic                                link_tx_valid,
    input wire logic [NUM_FAST-1:0]                 link_tx_fast,
    input wire logic [NUM_PEERS-1:0]                link_rx_valid,
    input wire logic [NUM_PEERS-1:0][NUM_FAST-1:0]  link_rx_fast,
    input wire logic [NUM_PEERS-1:0][GRP_IDX_W-1:0] link_rx_grp,
    input wire logic [NUM_PEERS-1:0][GRP_BITS-1:0]  link_rx_bg,
    input wire logic [NUM_PEERS-1:0]                link_fault,
    input wire logic [NUM_PEERS-1:0]                peer_active,
    input wire logic [NUM_PEERS-1:0][NUM_FAST-1:0]  fast_trip_rx,
    input wire logic [NUM_PEERS-1:0][NUM_GEN-1:0]   gen_rx,
    input wire logic [NUM_PEERS-1:0]                peer_avail
);
    localparam int FR_MAX = FRAME_CYCLES;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Peer 0 steady, and a good frame from peer 0
    sequence s_steady0;
        (peer_active[0] && !link_fault[0]) [*8];
    endsequence
    sequence s_frame0;
        link_rx_valid[0] && !link_fault[0];
    endsequence
    // Write answer ends once taken
    b_done_a: assert property (bvalid && bready |=> !bvalid)
        else $error("b held");
    tx_stand_a: assert property ($changed(link_tx_fast) |-> link_tx_valid)
        else $error("tx no frame");
    tx_period_a: assert property (
        link_tx_valid |-> ##[1:FR_MAX] link_tx_valid)
        else $error("tx gap");
    tx_follow_a: assert property (
        $stable(fast_trip_in) [*4] |-> link_tx_fast == fast_trip_in)
        else $error("tx fast");
    rx_fast_a: assert property (
        s_frame0 |=> fast_trip_rx[0] == $past(link_rx_fast[0]))
        else $error("rx fast");
    rx_group_a: assert property (
        s_frame0 ##0 link_rx_grp[0] == 3'h2
        |=> gen_rx[0][11:8] == $past(link_rx_bg[0]))
        else $error("rx group");
    rx_refuse_a: assert property (
        link_rx_valid[1] && link_fault[1] |=> fast_trip_rx[1] ==
        $past(fast_trip_rx[1]) || fast_trip_rx[1] == 4'h0)
        else $error("rx in fault");
    avail_drop_a: assert property (
        !peer_active[1] || link_fault[1] |=> !peer_avail[1])
        else $error("avail held");
    avail_rise_a: assert property (s_steady0 |-> ##[1:2] peer_avail[0])
        else $error("avail late");
endmodule // rbst_asserts
bind remote_binary_signal_transfer rbst_asserts #(
    .NUM_PEERS(NUM_PEERS), .FRAME_CYCLES(FRAME_CYCLES)
) rbst_asserts_inst (.*);
`default_nettype wire

/* File: rbst_peer.sv */
// Model of the peer relays at the far end of the link
`timescale 1ns/100ps
`default_nettype none
module rbst_peer
    import rbst_pkg::*;
#(
    parameter int NUM_PEERS = NUM_PEERS_DEF
)
(
    input  wire logic                                core_clk,
    input  wire logic                                rst,
    input  wire logic [NUM_PEERS-1:0][NUM_FAST-1:0]  img_fast,
    input  wire logic [NUM_PEERS-1:0][NUM_GEN-1:0]   img_gen,
    input  wire logic [7:0]                          gap,
    output logic      [NUM_PEERS-1:0]                link_rx_valid,
    output logic      [NUM_PEERS-1:0][NUM_FAST-1:0]  link_rx_fast,
    output logic      [NUM_PEERS-1:0][GRP_IDX_W-1:0] link_rx_grp,
    output logic      [NUM_PEERS-1:0][GRP_BITS-1:0]  link_rx_bg,
    input  wire logic                                link_tx_valid,
    input  wire logic [NUM_FAST-1:0]                 link_tx_fast,
    input  wire logic [GRP_IDX_W-1:0]                link_tx_grp,
    input  wire logic [GRP_BITS-1:0]                 link_tx_bg,
    output logic      [NUM_FAST-1:0]                 far_fast,
    output logic      [NUM_GEN-1:0]                  far_gen
);
    logic [7:0] cnt;
    logic [2:0] grp;
    // Frames every gap+1 cycles; idle payload toggles
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            {cnt, grp, link_rx_valid} <= '0;
            {link_rx_fast, link_rx_grp, link_rx_bg} <= '0;
            {far_fast, far_gen} <= '0;
        end
        else
        begin
            cnt <= (cnt >= gap) ? 8'h00 : cnt + 8'h01;
            link_rx_valid <= {NUM_PEERS{cnt >= gap}};
            link_rx_fast <= ~link_rx_fast;
            link_rx_grp <= ~link_rx_grp;
            link_rx_bg <= ~link_rx_bg;
            if (cnt >= gap)
            begin
                grp <= (grp == 3'h5) ? 3'h0 : grp + 3'h1;
                for (int p = 0; p < NUM_PEERS; p++)
                begin
                    link_rx_fast[p] <= img_fast[p];
                    link_rx_grp[p] <= grp;
                    link_rx_bg[p] <= img_gen[p][grp*4 +: 4];
                end
            end
            if (link_tx_valid)
                far_fast <= link_tx_fast;
            if (link_tx_valid && link_tx_grp < 3'h6)
                far_gen[link_tx_grp*4 +: 4] <= link_tx_bg;
        end
    end
endmodule // rbst_peer
`default_nettype wire

/* File: test_remote_binary_signal_transfer.sv */
// Bench for the remote binary signal transfer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            num_errors++; \
            $display("BAD %s exp %h got %h", nm, ex, got); \
        end \
    end
module test_remote_binary_signal_transfer;
    import rbst_pkg::*;
    localparam int P = 2;
    logic               core_clk = 1'b0;
    logic               rst;
    logic [7:0]         awaddr = '0, araddr = '0, gap = '0;
    logic [31:0]        wdata = '0, rdata, rd;
    logic [3:0]         wstrb = 4'hf, fast_trip_in = '0;
    logic               awvalid = '0, wvalid = '0, bready = '0;
    logic               arvalid = '0, rready = '0;
    logic               awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]         bresp, rresp, rs;
    logic [23:0]        gen_in = '0, far_gen;
    logic               functional_logout = '0, link_tx_valid;
    logic [P-1:0]       peer_active = '0, link_fault = '0;
    logic [P-1:0]       link_rx_valid, peer_avail;
    logic [3:0]         link_tx_fast, link_tx_bg, far_fast;
    logic [2:0]         link_tx_grp;
    logic [P-1:0][3:0]  link_rx_fast, link_rx_bg, fast_trip_rx;
    logic [P-1:0][3:0]  img_fast = '0;
    logic [P-1:0][2:0]  link_rx_grp;
    logic [P-1:0][23:0] gen_rx, img_gen = '0;
    int                 num_errors = 0, samples_checked = 0, cycles = 0;

    remote_binary_signal_transfer #(
        .NUM_PEERS(P), .FRAME_CYCLES(8), .STABLE_CYCLES(8), .MS_CYCLES(4)
    ) remote_binary_signal_transfer_inst (.*);
    rbst_peer #(.NUM_PEERS(P)) rbst_peer_inst (.*);

    always #4 core_clk = ~core_clk;

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cut a hung run short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // Register write
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    // Register read
    task automatic axi_rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Wait some clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Main sequence
    initial
    begin
        rst = 1'b1;
        tick(8);
        rst <= 1'b0;
        peer_active <= 2'b11;
        functional_logout <= 1'b1;
        tick(2);
        axi_rd(REG_DELAY);
        `CHK("delay reset", 32'h0, rd)
        axi_rd(8'h40);
        `CHK("unmapped", RESP_SLVERR, rs)
        axi_wr(REG_DELAY, 32'h0007ffff);
        axi_rd(REG_DELAY);
        `CHK("delay top", 32'h000493e0, rd)
        axi_wr(REG_DELAY, 32'h0);
        // Sending while logged out
        fast_trip_in <= 4'ha;
        gen_in <= 24'h5a3c96;
        tick(6);
        `CHK("far fast", 4'ha, far_fast)
        tick(60);
        `CHK("far gen", 24'h5a3c96, far_gen)
        axi_rd(REG_TX_IMAGE);
        `CHK("tx image", 32'h05a3c96a, rd)
        // Back-to-back frames, then a slow peer
        img_fast <= {4'h3, 4'hc};
        img_gen <= {24'hc0ffee, 24'h123456};
        tick(20);
        `CHK("rx fast", {4'h3, 4'hc}, fast_trip_rx)
        `CHK("rx gen", {24'hc0ffee, 24'h123456}, gen_rx)
        `CHK("avail", 2'b11, peer_avail)
        gap <= 8'h14;
        img_gen[0] <= 24'h0f0f0f;
        tick(140);
        `CHK("slow gen", 24'h0f0f0f, gen_rx[0])
        gap <= 8'h00;
        axi_rd(REG_IRQ_STAT);
        // Fault, zero delay, irq masked then not
        link_fault <= 2'b10;
        tick(4);
        `CHK("clr fast", {4'h0, 4'hc}, fast_trip_rx)
        `CHK("clr gen", 24'h0, gen_rx[1])
        `CHK("avail lost", 2'b01, peer_avail)
        `CHK("irq masked", 1'b0, irq)
        axi_wr(REG_IRQ_MASK, 32'h0000000a);
        tick(2);
        `CHK("irq raised", 1'b1, irq)
        axi_rd(REG_IRQ_STAT);
        `CHK("irq status", 32'h0000000a, rd)
        tick(2);
        `CHK("irq cleared", 1'b0, irq)
        link_fault <= 2'b00;
        tick(20);
        `CHK("rx back", 24'hc0ffee, gen_rx[1])
        // Three ms delay: held, then cleared
        axi_wr(REG_DELAY, 32'h3);
        link_fault <= 2'b10;
        tick(8);
        `CHK("held", 24'hc0ffee, gen_rx[1])
        tick(12);
        `CHK("expired", 24'h0, gen_rx[1])
        // Infinite delay; frames during fault ignored
        axi_wr(REG_DELAY, 32'h80000000);
        link_fault <= 2'b00;
        tick(20);
        link_fault <= 2'b10;
        img_gen[1] <= 24'h000111;
        tick(100);
        `CHK("never clr", 24'hc0ffee, gen_rx[1])
        tally_and_finish();
    end
endmodule // test_remote_binary_signal_transfer
`default_nettype wire
